// file: hdl/cpsf_core.sv
// Working register, program counter low, table pointers and status flags.
// Assumes an Avalon-MM master on core_clk and a table ROM answering in the same cycle.
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "cpsf_defines.svh"

// Notes on behaviour
// RULE1: Every ALU result lands in the working register. An increment or decrement aimed at a table pointer writes that pointer instead.
// RULE2: No register-to-register move; data passes through the working register.
// RULE3: Writing program counter low jumps within the current page.
// RULE4: A program counter low write inserts one dummy cycle.
// RULE5: Table pointer pair addresses table reads; writable, incrementable, decrementable.
// RULE6: Table read puts high byte in table data high, low byte elsewhere.
// RULE7: Status bits: sign-xor, combined, expiry, sleep, range, zero, half, carry.
// RULE8: Status data writes never change expiry or sleep flags.
// RULE9: Expiry flag cleared by reset, kick, sleep; set by watchdog expiry.
// RULE10: Sleep flag cleared by reset or kick; set by sleep.
// RULE11: Carry is carry-out or no-borrow; rotates through carry update it.
// RULE12: Half flag is low nibble carry or no nibble borrow.
// RULE13: Zero flag set when the operation result is zero.
// RULE14: Range flag is carry into MSB differing from carry out.
// RULE15: Sign-xor flag is range flag xor result MSB.
// RULE16: Combined flag source depends on the executing instruction.
// RULE17: Status is never saved automatically on interrupt or call.
// RULE18: Instructions without combined result leave the combined flag unchanged.
module cpsf_core #(
	parameter int PCW = 13
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic wdt_expire_pin,
	input wire logic instr_step,
	input wire logic [15:0] prog_word,
	output logic [15:0] prog_addr,
	output logic [PCW-1:0] pc,
	output logic dummy_cycle,
	output logic irq
);
	function automatic logic [10:0] cpsf_add(input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		logic [4:0] lo;
		logic [3:0] mid;
		logic [1:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
		hi = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
		// Packed as range, half, carry, result
		return {mid[3] ^ hi[1], lo[4], hi[1], hi[0], mid[2:0], lo[3:0]};
	endfunction

	cpsf_pkg::cpsf_state_t state, next_state;
	logic next_waitrequest;
	logic [31:0] next_readdata;
	logic [7:0] acc, next_acc;
	logic [7:0] table_pointer_low, next_table_pointer_low;
	logic [7:0] table_pointer_high, next_table_pointer_high;
	logic [7:0] table_data_high, next_table_data_high;
	logic [7:0] tbll, next_tbll;
	logic [7:0] stat, next_stat;
	logic [PCW-1:0] next_pc;
	logic next_dummy;
	logic [2:0] irq_stat, next_irq_stat;
	logic [2:0] irq_mask, next_irq_mask;
	logic next_irq;
	logic wdt_s1, wdt_s2, wdt_s3, wdt_lvl, next_wdt_lvl;
	logic wdt_evt;
	logic do_wr, lane0;
	cpsf_pkg::cpsf_op_t op;
	logic [7:0] opd;
	logic [10:0] ar;
	logic [7:0] step_val;
	logic [2:0] events;

	assign prog_addr = {table_pointer_high, table_pointer_low}; // RULE5
	assign do_wr = (state == cpsf_pkg::CPSF_ST_ACK) && avs_write;
	assign lane0 = avs_byteenable[0];
	assign op = cpsf_pkg::cpsf_op_t'(avs_writedata[3:0]);
	assign opd = avs_writedata[15:8];
	// Watchdog expiry counts once the second and third stages are both high while the held level is low
	assign wdt_evt = wdt_s2 && wdt_s3 && !wdt_lvl;

	// Bus handshake: one wait cycle, then a single-cycle answer
	always_comb begin
		next_state = cpsf_pkg::CPSF_ST_IDLE;
		next_readdata = avs_readdata;
		case (state)
			cpsf_pkg::CPSF_ST_IDLE: begin
				if (avs_read || avs_write) begin
					next_state = cpsf_pkg::CPSF_ST_ACK;
				end
				next_readdata = 32'h0000_0000;
				if (avs_read) begin
					case (avs_address)
						`CPSF_OFS_ACC: next_readdata[7:0] = acc;
						`CPSF_OFS_PCL: next_readdata[7:0] = pc[7:0];
						`CPSF_OFS_TABLE_POINTER_LOW: next_readdata[7:0] = table_pointer_low;
						`CPSF_OFS_TABLE_POINTER_HIGH: next_readdata[7:0] = table_pointer_high;
						`CPSF_OFS_TABLE_DATA_HIGH: next_readdata[7:0] = table_data_high;
						`CPSF_OFS_STAT: next_readdata[7:0] = stat; // RULE7
						`CPSF_OFS_TBLL: next_readdata[7:0] = tbll;
						`CPSF_OFS_PCH: next_readdata[PCW-9:0] = pc[PCW-1:8];
						`CPSF_OFS_IRQS: next_readdata[2:0] = irq_stat;
						`CPSF_OFS_IRQM: next_readdata[2:0] = irq_mask;
						default: next_readdata = 32'h0000_0000;
					endcase
				end
			end
			cpsf_pkg::CPSF_ST_ACK: next_state = cpsf_pkg::CPSF_ST_IDLE;
			default: next_state = cpsf_pkg::CPSF_ST_IDLE;
		endcase
		next_waitrequest = (next_state != cpsf_pkg::CPSF_ST_ACK);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= cpsf_pkg::CPSF_ST_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			state <= next_state;
			avs_waitrequest <= next_waitrequest;
			avs_readdata <= next_readdata;
		end
	end

	// Datapath, flags and program counter
	always_comb begin
		next_acc = acc;
		next_table_pointer_low = table_pointer_low;
		next_table_pointer_high = table_pointer_high;
		next_table_data_high = table_data_high;
		next_tbll = tbll;
		next_stat = stat; // RULE18
		next_pc = pc;
		next_dummy = 1'b0;
		events = `CPSF_EV_RST;
		ar = 11'h000;
		step_val = 8'h00;
		if (instr_step && !dummy_cycle) begin
			next_pc = pc + PCW'(1);
		end
		if (do_wr && lane0) begin
			case (avs_address)
				`CPSF_OFS_ACC: next_acc = avs_writedata[7:0];
				`CPSF_OFS_TABLE_POINTER_LOW: next_table_pointer_low = avs_writedata[7:0]; // RULE5
				`CPSF_OFS_TABLE_POINTER_HIGH: next_table_pointer_high = avs_writedata[7:0]; // RULE5
				`CPSF_OFS_PCL: begin
					next_pc = {pc[PCW-1:8], avs_writedata[7:0]}; // RULE3
					next_dummy = 1'b1; // RULE4
					events[`CPSF_EV_JMP] = 1'b1;
				end
				`CPSF_OFS_STAT: begin
					// Sign-xor and combined are read-only; expiry and sleep kept
					next_stat = (stat & ~`CPSF_STAT_WMASK) |
						(avs_writedata[7:0] & `CPSF_STAT_WMASK); // RULE8
				end
				`CPSF_OFS_OP: begin
					case (op)
						cpsf_pkg::CPSF_OP_ADD, cpsf_pkg::CPSF_OP_ADC,
						cpsf_pkg::CPSF_OP_SUB, cpsf_pkg::CPSF_OP_SBC: begin
							if (op == cpsf_pkg::CPSF_OP_ADD) begin
								ar = cpsf_add(acc, opd, 1'b0);
							end else if (op == cpsf_pkg::CPSF_OP_ADC) begin
								ar = cpsf_add(acc, opd, stat[`CPSF_B_C]);
							end else if (op == cpsf_pkg::CPSF_OP_SUB) begin
								ar = cpsf_add(acc, ~opd, 1'b1);
							end else begin
								ar = cpsf_add(acc, ~opd, stat[`CPSF_B_C]);
							end
							next_acc = ar[7:0]; // RULE1
							next_stat[`CPSF_B_C] = ar[8]; // RULE11
							next_stat[`CPSF_B_AC] = ar[9]; // RULE12
							next_stat[`CPSF_B_OV] = ar[10]; // RULE14
							next_stat[`CPSF_B_Z] = (ar[7:0] == 8'h00); // RULE13
							next_stat[`CPSF_B_SC] = ar[10] ^ ar[7]; // RULE15
							// Plain subtract copies zero; carried subtract chains it
							if (op == cpsf_pkg::CPSF_OP_SUB) begin
								next_stat[`CPSF_B_CZ] = (ar[7:0] == 8'h00); // RULE16
							end else if (op == cpsf_pkg::CPSF_OP_SBC) begin
								next_stat[`CPSF_B_CZ] = stat[`CPSF_B_CZ] &&
									(ar[7:0] == 8'h00); // RULE16
							end
						end
						cpsf_pkg::CPSF_OP_AND, cpsf_pkg::CPSF_OP_OR,
						cpsf_pkg::CPSF_OP_XOR: begin
							if (op == cpsf_pkg::CPSF_OP_AND) begin
								next_acc = acc & opd; // RULE1
							end else if (op == cpsf_pkg::CPSF_OP_OR) begin
								next_acc = acc | opd;
							end else begin
								next_acc = acc ^ opd;
							end
							next_stat[`CPSF_B_Z] = (next_acc == 8'h00); // RULE13
						end
						cpsf_pkg::CPSF_OP_RRC: begin
							next_acc = {stat[`CPSF_B_C], acc[7:1]}; // RULE1
							next_stat[`CPSF_B_C] = acc[0]; // RULE11
						end
						cpsf_pkg::CPSF_OP_RLC: begin
							next_acc = {acc[6:0], stat[`CPSF_B_C]};
							next_stat[`CPSF_B_C] = acc[7]; // RULE11
						end
						cpsf_pkg::CPSF_OP_MOVA: next_acc = opd;
						cpsf_pkg::CPSF_OP_STORE: begin
							// Second half of any register transfer
							case (opd[1:0])
								`CPSF_TGT_TABLE_POINTER_LOW: next_table_pointer_low = acc; // RULE2
								`CPSF_TGT_TABLE_POINTER_HIGH: next_table_pointer_high = acc; // RULE2
								`CPSF_TGT_PCL: begin
									next_pc = {pc[PCW-1:8], acc}; // RULE3
									next_dummy = 1'b1; // RULE4
									events[`CPSF_EV_JMP] = 1'b1;
								end
								default: next_acc = acc;
							endcase
						end
						cpsf_pkg::CPSF_OP_INCR, cpsf_pkg::CPSF_OP_DECR: begin
							case (opd[1:0])
								`CPSF_TGT_TABLE_POINTER_LOW: step_val = table_pointer_low;
								`CPSF_TGT_TABLE_POINTER_HIGH: step_val = table_pointer_high;
								default: step_val = acc;
							endcase
							if (op == cpsf_pkg::CPSF_OP_INCR) begin
								step_val = step_val + 8'h01;
							end else begin
								step_val = step_val - 8'h01;
							end
							next_stat[`CPSF_B_Z] = (step_val == 8'h00); // RULE13
							case (opd[1:0])
								`CPSF_TGT_TABLE_POINTER_LOW: next_table_pointer_low = step_val; // RULE5
								`CPSF_TGT_TABLE_POINTER_HIGH: next_table_pointer_high = step_val; // RULE5
								default: next_acc = step_val;
							endcase
						end
						cpsf_pkg::CPSF_OP_TBLRD: begin
							next_table_data_high = prog_word[15:8]; // RULE6
							next_tbll = prog_word[7:0]; // RULE6
							events[`CPSF_EV_TBL] = 1'b1;
						end
						cpsf_pkg::CPSF_OP_KICK: begin
							next_stat[`CPSF_B_PDF] = 1'b0; // RULE10
							next_stat[`CPSF_B_TO] = 1'b0; // RULE9
						end
						cpsf_pkg::CPSF_OP_SLEEP: begin
							next_stat[`CPSF_B_PDF] = 1'b1; // RULE10
							next_stat[`CPSF_B_TO] = 1'b0; // RULE9
						end
						default: next_acc = acc;
					endcase
				end
				default: next_acc = acc;
			endcase
		end
		// Expiry beats a kick or sleep landing in the same cycle
		if (wdt_evt) begin
			next_stat[`CPSF_B_TO] = 1'b1; // RULE9
			events[`CPSF_EV_WDT] = 1'b1;
		end
		// Sticky events, write one to clear; a new event wins over the clear
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		if (do_wr && lane0 && avs_address == `CPSF_OFS_IRQS) begin
			next_irq_stat = irq_stat & ~avs_writedata[2:0];
		end
		if (do_wr && lane0 && avs_address == `CPSF_OFS_IRQM) begin
			next_irq_mask = avs_writedata[2:0];
		end
		next_irq_stat = next_irq_stat | events;
		next_irq = |(next_irq_stat & next_irq_mask);
		next_wdt_lvl = (wdt_s2 == wdt_s3) ? wdt_s3 : wdt_lvl;
	end

	// Status is not stacked on calls or interrupts; software saves it
	always_ff @(posedge core_clk) begin // RULE17
		if (rst) begin
			acc <= 8'h00;
			table_pointer_low <= 8'h00;
			table_pointer_high <= 8'h00;
			table_data_high <= 8'h00;
			tbll <= 8'h00;
			stat <= `CPSF_STAT_RST;
			pc <= '0;
			dummy_cycle <= 1'b0;
			irq_stat <= `CPSF_EV_RST;
			irq_mask <= `CPSF_EV_RST;
			irq <= 1'b0;
			wdt_s1 <= 1'b0;
			wdt_s2 <= 1'b0;
			wdt_s3 <= 1'b0;
			wdt_lvl <= 1'b0;
		end else begin
			acc <= next_acc;
			table_pointer_low <= next_table_pointer_low;
			table_pointer_high <= next_table_pointer_high;
			table_data_high <= next_table_data_high;
			tbll <= next_tbll;
			stat <= next_stat;
			pc <= next_pc;
			dummy_cycle <= next_dummy;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			irq <= next_irq;
			wdt_s1 <= wdt_expire_pin;
			wdt_s2 <= wdt_s1;
			wdt_s3 <= wdt_s2;
			wdt_lvl <= next_wdt_lvl;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	logic op_wr, pcl_wr, arith;
	assign op_wr = do_wr && lane0 && avs_address == `CPSF_OFS_OP;
	assign pcl_wr = do_wr && lane0 && avs_address == `CPSF_OFS_PCL;
	assign arith = op_wr && (op == cpsf_pkg::CPSF_OP_ADD || op == cpsf_pkg::CPSF_OP_SUB);

	sequence s_jump_req;
		pcl_wr;
	endsequence
	sequence s_dummy_once;
		dummy_cycle ##1 !dummy_cycle;
	endsequence
	// A held request is answered once; only the idle-state sample is new
	sequence s_bus_req;
		(avs_read || avs_write) && state == cpsf_pkg::CPSF_ST_IDLE;
	endsequence

	a_bus_answer: assert property (s_bus_req |=> !avs_waitrequest)
		else $error("bus answer late");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait request low too long");
	a_alu_result: assert property ((op_wr && op == cpsf_pkg::CPSF_OP_ADD) |=> // RULE1
		acc == ($past(acc) + $past(opd)))
		else $error("alu sum not in working register");
	a_alu_sub: assert property ((op_wr && op == cpsf_pkg::CPSF_OP_SUB) |=> // RULE1
		acc == ($past(acc) - $past(opd)))
		else $error("alu difference not in working register");
	a_sub_carry: assert property ((op_wr && op == cpsf_pkg::CPSF_OP_SUB) |=> // RULE11
		stat[`CPSF_B_C] == ($past(acc) >= $past(opd)))
		else $error("carry is not the no-borrow flag");
	a_pcl_page: assert property (s_jump_req |=> // RULE3
		pc[7:0] == $past(avs_writedata[7:0]) && pc[PCW-1:8] == $past(pc[PCW-1:8]))
		else $error("jump left the page");
	a_dummy_insert: assert property (s_jump_req |=> s_dummy_once) // RULE4
		else $error("dummy cycle missing");
	a_table_high: assert property ((op_wr && op == cpsf_pkg::CPSF_OP_TBLRD) |=> // RULE6
		table_data_high == $past(prog_word[15:8]) && tbll == $past(prog_word[7:0]))
		else $error("table read bytes wrong");
	a_stat_keep: assert property ((do_wr && avs_address == `CPSF_OFS_STAT && !wdt_evt) |=> // RULE8
		$stable(stat[`CPSF_B_TO]) && $stable(stat[`CPSF_B_PDF]))
		else $error("status write touched system flags");
	a_expiry_set: assert property (wdt_evt |=> stat[`CPSF_B_TO]) // RULE9
		else $error("expiry flag not set");
	a_sleep_flags: assert property ((op_wr && op == cpsf_pkg::CPSF_OP_SLEEP && !wdt_evt) |=> // RULE10
		stat[`CPSF_B_PDF] && !stat[`CPSF_B_TO])
		else $error("sleep flags wrong");
	a_kick_clear: assert property ((op_wr && op == cpsf_pkg::CPSF_OP_KICK && !wdt_evt) |=> // RULE10
		!stat[`CPSF_B_PDF] && !stat[`CPSF_B_TO])
		else $error("kick left system flags set");
	a_zero_flag: assert property (arith |=> stat[`CPSF_B_Z] == (acc == 8'h00)) // RULE13
		else $error("zero flag wrong");
	a_sign_xor: assert property (arith |=> // RULE15
		stat[`CPSF_B_SC] == (stat[`CPSF_B_OV] ^ acc[7]))
		else $error("sign-xor flag wrong");
	a_sbc_chain: assert property ((op_wr && op == cpsf_pkg::CPSF_OP_SBC) |=> // RULE16
		stat[`CPSF_B_CZ] == ($past(stat[`CPSF_B_CZ]) && acc == 8'h00))
		else $error("combined flag not chained");
	a_cz_hold: assert property ((op_wr && op == cpsf_pkg::CPSF_OP_AND) |=> // RULE18
		$stable(stat[`CPSF_B_CZ]))
		else $error("combined flag changed");
endmodule
`default_nettype wire

// file: hdl/cpsf_defines.svh
// Constants for the CPU status flag and special register block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, words aligned.
`ifndef CPSF_DEFINES_SVH
`define CPSF_DEFINES_SVH

// Register byte offsets
`define CPSF_OFS_ACC 6'h00
`define CPSF_OFS_PCL 6'h04
`define CPSF_OFS_TABLE_POINTER_LOW 6'h08
`define CPSF_OFS_TABLE_POINTER_HIGH 6'h0C
`define CPSF_OFS_TABLE_DATA_HIGH 6'h10
`define CPSF_OFS_STAT 6'h14
`define CPSF_OFS_OP 6'h18
`define CPSF_OFS_TBLL 6'h1C
`define CPSF_OFS_PCH 6'h20
`define CPSF_OFS_IRQS 6'h24
`define CPSF_OFS_IRQM 6'h28

// Status flag bit positions
`define CPSF_B_C 0
`define CPSF_B_AC 1
`define CPSF_B_Z 2
`define CPSF_B_OV 3
`define CPSF_B_PDF 4
`define CPSF_B_TO 5
`define CPSF_B_CZ 6
`define CPSF_B_SC 7
`define CPSF_STAT_WMASK 8'h0F
`define CPSF_STAT_RST 8'h00

// Event bits of interrupt status and mask
`define CPSF_EV_WDT 0
`define CPSF_EV_JMP 1
`define CPSF_EV_TBL 2
`define CPSF_EV_RST 3'h0

// Store and step targets in the operand byte
`define CPSF_TGT_ACC 2'h0
`define CPSF_TGT_TABLE_POINTER_LOW 2'h1
`define CPSF_TGT_TABLE_POINTER_HIGH 2'h2
`define CPSF_TGT_PCL 2'h3

`endif

// file: hdl/cpsf_pkg.sv
// Types for the CPU status flag and special register block.
// Assumes cpsf_defines.svh supplies the numeric constants.
package cpsf_pkg;
	typedef enum logic [3:0] {
		CPSF_OP_ADD = 4'h0,
		CPSF_OP_ADC = 4'h1,
		CPSF_OP_SUB = 4'h2,
		CPSF_OP_SBC = 4'h3,
		CPSF_OP_AND = 4'h4,
		CPSF_OP_OR = 4'h5,
		CPSF_OP_XOR = 4'h6,
		CPSF_OP_RRC = 4'h7,
		CPSF_OP_RLC = 4'h8,
		CPSF_OP_MOVA = 4'h9,
		CPSF_OP_STORE = 4'hA,
		CPSF_OP_INCR = 4'hB,
		CPSF_OP_DECR = 4'hC,
		CPSF_OP_TBLRD = 4'hD,
		CPSF_OP_KICK = 4'hE,
		CPSF_OP_SLEEP = 4'hF
	} cpsf_op_t;
	typedef enum logic [1:0] {
		CPSF_ST_IDLE = 2'b01,
		CPSF_ST_ACK = 2'b10
	} cpsf_state_t;
endpackage

// file: sim/testbench.sv
// Self-checking bench for the CPU status flag and special register block.
// Assumes cpsf_core, cpsf_pkg and cpsf_defines.svh are compiled alongside it.
`timescale 1ns/1ns
`default_nettype none
`include "cpsf_defines.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("BAD t=%0t got %h exp %h", $time, (got), (exp)); end end

module testbench;
	logic core_clk;
	logic rst;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic wdt_expire_pin;
	logic instr_step;
	logic [15:0] prog_word;
	logic [15:0] prog_addr;
	logic [12:0] pc;
	logic dummy_cycle;
	logic irq;
	logic [3:0] be_cur;
	int n_errors = 0;
	int n_checks = 0;
	int n_dummy = 0;

	cpsf_core #(.PCW(13)) uut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .wdt_expire_pin(wdt_expire_pin),
		.instr_step(instr_step), .prog_word(prog_word), .prog_addr(prog_addr), .pc(pc),
		.dummy_cycle(dummy_cycle), .irq(irq));

	// ROM pattern differs per byte so a swapped pointer half shows up
	always_comb prog_word = {prog_addr[7:0], ~prog_addr[15:8]};

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk) if (dummy_cycle === 1'b1) n_dummy <= n_dummy + 1;

	task automatic summarize();
		$display("Checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic wait_ack();
		int k;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 40);
		if (avs_waitrequest !== 1'b0) begin
			n_errors++;
			$display("BAD t=%0t no answer from slave", $time);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be_cur;
		avs_write <= 1'b1;
		wait_ack();
		avs_write <= 1'b0;
	endtask

	task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		wait_ack();
		`CHK(avs_readdata, e)
		avs_read <= 1'b0;
	endtask

	task automatic alu(input cpsf_pkg::cpsf_op_t op, input logic [7:0] opd,
		input logic [7:0] e_acc, input logic [7:0] e_st);
		wr(`CPSF_OFS_OP, {16'h0000, opd, 4'h0, op});
		rdchk(`CPSF_OFS_ACC, {24'h000000, e_acc});
		rdchk(`CPSF_OFS_STAT, {24'h000000, e_st});
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		$display("BAD t=%0t run did not complete", $time);
		summarize();
	end

	initial begin
		rst = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		wdt_expire_pin = 1'b0;
		instr_step = 1'b0;
		be_cur = 4'hF;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		`CHK(pc, 13'h0000)
		`CHK(prog_addr, 16'h0000)
		`CHK(irq, 1'b0)
		rdchk(`CPSF_OFS_STAT, 32'h00000000);
		alu(cpsf_pkg::CPSF_OP_MOVA, 8'h7F, 8'h7F, 8'h00);
		alu(cpsf_pkg::CPSF_OP_ADD, 8'h01, 8'h80, 8'h0A);
		alu(cpsf_pkg::CPSF_OP_ADC, 8'h7F, 8'hFF, 8'h80);
		alu(cpsf_pkg::CPSF_OP_ADD, 8'h01, 8'h00, 8'h07);
		alu(cpsf_pkg::CPSF_OP_ADC, 8'h00, 8'h01, 8'h00);
		alu(cpsf_pkg::CPSF_OP_MOVA, 8'h10, 8'h10, 8'h00);
		alu(cpsf_pkg::CPSF_OP_SUB, 8'h10, 8'h00, 8'h47);
		alu(cpsf_pkg::CPSF_OP_MOVA, 8'h00, 8'h00, 8'h47);
		alu(cpsf_pkg::CPSF_OP_SBC, 8'h01, 8'hFF, 8'h80);
		alu(cpsf_pkg::CPSF_OP_SBC, 8'hFE, 8'h00, 8'h07);
		alu(cpsf_pkg::CPSF_OP_MOVA, 8'h0F, 8'h0F, 8'h07);
		alu(cpsf_pkg::CPSF_OP_AND, 8'h0F, 8'h0F, 8'h03);
		alu(cpsf_pkg::CPSF_OP_OR, 8'h30, 8'h3F, 8'h03);
		alu(cpsf_pkg::CPSF_OP_XOR, 8'h3F, 8'h00, 8'h07);
		alu(cpsf_pkg::CPSF_OP_MOVA, 8'h02, 8'h02, 8'h07);
		alu(cpsf_pkg::CPSF_OP_RRC, 8'h00, 8'h81, 8'h06);
		alu(cpsf_pkg::CPSF_OP_RLC, 8'h00, 8'h02, 8'h07);
		alu(cpsf_pkg::CPSF_OP_MOVA, 8'hFF, 8'hFF, 8'h07);
		alu(cpsf_pkg::CPSF_OP_INCR, 8'h00, 8'h00, 8'h07);
		alu(cpsf_pkg::CPSF_OP_DECR, 8'h00, 8'hFF, 8'h03);
		// Table pointer set up both through the working register and directly
		alu(cpsf_pkg::CPSF_OP_MOVA, 8'h34, 8'h34, 8'h03);
		alu(cpsf_pkg::CPSF_OP_STORE, 8'h01, 8'h34, 8'h03);
		wr(`CPSF_OFS_TABLE_POINTER_HIGH, 32'h00000012);
		alu(cpsf_pkg::CPSF_OP_INCR, 8'h01, 8'h34, 8'h03);
		alu(cpsf_pkg::CPSF_OP_DECR, 8'h02, 8'h34, 8'h03);
		rdchk(`CPSF_OFS_TABLE_POINTER_LOW, 32'h00000035);
		rdchk(`CPSF_OFS_TABLE_POINTER_HIGH, 32'h00000011);
		`CHK(prog_addr, 16'h1135)
		wr(`CPSF_OFS_OP, {24'h000000, 4'h0, cpsf_pkg::CPSF_OP_TBLRD});
		rdchk(`CPSF_OFS_TABLE_DATA_HIGH, 32'h00000035);
		rdchk(`CPSF_OFS_TBLL, 32'h000000EE);
		rdchk(`CPSF_OFS_IRQS, 32'h00000004);
		wr(`CPSF_OFS_IRQS, 32'h00000004);
		rdchk(`CPSF_OFS_IRQS, 32'h00000000);
		wr(`CPSF_OFS_TABLE_DATA_HIGH, 32'h00000000);
		rdchk(`CPSF_OFS_TABLE_DATA_HIGH, 32'h00000035);
		rdchk(6'h3C, 32'h00000000);
		be_cur = 4'h0;
		wr(`CPSF_OFS_ACC, 32'h00000055);
		be_cur = 4'hF;
		rdchk(`CPSF_OFS_ACC, 32'h00000034);
		// System flags against data writes, sleep, kick and expiry
		alu(cpsf_pkg::CPSF_OP_SLEEP, 8'h00, 8'h34, 8'h13);
		wr(`CPSF_OFS_STAT, 32'h000000FF);
		rdchk(`CPSF_OFS_STAT, 32'h0000001F);
		wr(`CPSF_OFS_STAT, 32'h000000E0);
		rdchk(`CPSF_OFS_STAT, 32'h00000010);
		alu(cpsf_pkg::CPSF_OP_KICK, 8'h00, 8'h34, 8'h00);
		wdt_expire_pin <= 1'b1;
		repeat (8) @(posedge core_clk);
		rdchk(`CPSF_OFS_STAT, 32'h00000020);
		rdchk(`CPSF_OFS_IRQS, 32'h00000001);
		`CHK(irq, 1'b0)
		wr(`CPSF_OFS_IRQM, 32'h00000007);
		repeat (2) @(posedge core_clk);
		`CHK(irq, 1'b1)
		wr(`CPSF_OFS_STAT, 32'h00000000);
		rdchk(`CPSF_OFS_STAT, 32'h00000020);
		alu(cpsf_pkg::CPSF_OP_SLEEP, 8'h00, 8'h34, 8'h10);
		alu(cpsf_pkg::CPSF_OP_KICK, 8'h00, 8'h34, 8'h00);
		wr(`CPSF_OFS_IRQS, 32'h00000001);
		repeat (2) @(posedge core_clk);
		`CHK(irq, 1'b0)
		wdt_expire_pin <= 1'b0;
		// Walk past a page boundary so the held upper bits are non-zero
		instr_step <= 1'b1;
		repeat (300) @(posedge core_clk);
		instr_step <= 1'b0;
		@(posedge core_clk);
		`CHK(pc, 13'h012C)
		wr(`CPSF_OFS_PCL, 32'h00000055);
		repeat (2) @(posedge core_clk);
		`CHK(pc, 13'h0155)
		`CHK(n_dummy, 1)
		rdchk(`CPSF_OFS_PCH, 32'h00000001);
		`CHK(irq, 1'b1)
		alu(cpsf_pkg::CPSF_OP_MOVA, 8'hAA, 8'hAA, 8'h00);
		alu(cpsf_pkg::CPSF_OP_STORE, 8'h03, 8'hAA, 8'h00);
		repeat (2) @(posedge core_clk);
		`CHK(pc, 13'h01AA)
		`CHK(n_dummy, 2)
		rdchk(`CPSF_OFS_IRQS, 32'h00000002);
		summarize();
	end
endmodule
`default_nettype wire
